// ### verilog/dfd_decoder.sv
// Instruction format decoder with cycle timing, flags and APB registers
module dfd_decoder import dfd_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  output logic fetch_ready,
  input wire logic ex_redirect,
  input wire logic ex_skip,
  input wire dfd_alu_upd_t ex_upd,
  output dfd_issue_t issue,
  output logic [4:0] mcu_flags,
  output logic [3:0] dsp_flags
);
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SECOND = 2'b01,
    ST_HOLD = 2'b10
  } dfd_state_t;

  dfd_state_t state_r;
  logic [23:0] first_r;
  logic [1:0] hold_cnt_r;
  logic [1:0] squash_cnt_r;
  logic skip_r;
  logic [31:0] ctrl_r;
  logic [4:0] mcu_r;
  logic [3:0] dsp_r;
  logic [15:0] icnt_r;
  logic [7:0] last_r;
  dfd_issue_t iss_r;
  logic accept;
  logic kill;
  dfd_cls_t live_cls;
  dfd_cls_t dec_cls;
  logic [23:0] dec_word;
  dfd_fields_t dec_fields;
  logic apb_wr;
  logic apb_setup;
  logic flags_wr;
  logic [22:0] jump_addr;

  // Fetch handshake: stalled while fixed bubbles are being issued
  assign fetch_ready = ctrl_r[`DFD_CTRL_EN] && (state_r != ST_HOLD);
  assign accept = fetch_valid && fetch_ready;
  assign live_cls = dfd_op_class(fetch_word[23:16]);
  // Squashing only hits whole words in the run state
  assign kill = accept && (squash_cnt_r != 2'd0) && (state_r == ST_RUN);

  // The held first word is decoded when its second word arrives
  assign dec_word = (state_r == ST_SECOND) ? first_r : fetch_word;
  assign dec_cls = dfd_op_class(dec_word[23:16]);

  dfd_opfields u_fields (
    .word(dec_word),
    .cls(dec_cls),
    .fields(dec_fields)
  );

  // Lowest bit forced clear; software is expected to keep it clear anyway
  assign jump_addr = {fetch_word[6:0], first_r[15:1], 1'b0};

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      first_r <= 24'h000000;
      hold_cnt_r <= 2'd0;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (accept && !kill) begin
            if (live_cls == DFD_CLS_TWO) begin
              first_r <= fetch_word;
              state_r <= ST_SECOND;
            end else if (dfd_fixed_extra(live_cls) != 2'd0) begin
              hold_cnt_r <= dfd_fixed_extra(live_cls);
              state_r <= ST_HOLD;
            end
          end
        end
        ST_SECOND: begin
          if (accept) begin
            state_r <= ST_RUN;
          end
        end
        ST_HOLD: begin
          hold_cnt_r <= hold_cnt_r - 2'd1;
          if (hold_cnt_r == 2'd1) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Squash counter; new feedback wins over a decrement in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      squash_cnt_r <= 2'd0;
      skip_r <= 1'b0;
    end else if (ex_redirect || ex_skip) begin
      squash_cnt_r <= 2'd1;
      skip_r <= ex_skip;
    end else if (kill) begin
      if (skip_r && live_cls == DFD_CLS_TWO) begin
        skip_r <= 1'b0;
      end else begin
        squash_cnt_r <= squash_cnt_r - 2'd1;
      end
    end
  end

  // Issue register toward the execution datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iss_r <= '0;
    end else begin
      iss_r <= '0;
      if (kill) begin
        iss_r.valid <= 1'b1;
        iss_r.bubble <= 1'b1;
        iss_r.cls <= DFD_CLS_NOP;
      end else if (accept && state_r == ST_SECOND) begin
        iss_r.valid <= 1'b1;
        iss_r.cls <= dec_cls;
        iss_r.opcode <= first_r[23:16];
        iss_r.cycles <= 2'd2;
        iss_r.program_address_constant <= jump_addr;
        iss_r.second_word_err <= fetch_word[23:16] != 8'h00;
        iss_r.fields <= dec_fields;
      end else if (accept && live_cls != DFD_CLS_TWO) begin
        // A lone second word has opcode zero and classes as a no-operation
        iss_r.valid <= 1'b1;
        iss_r.cls <= live_cls;
        iss_r.opcode <= fetch_word[23:16];
        iss_r.cycles <= 2'd1 + dfd_fixed_extra(live_cls);
        iss_r.fields <= dec_fields;
      end else if (state_r == ST_HOLD) begin
        iss_r.valid <= 1'b1;
        iss_r.bubble <= 1'b1;
        iss_r.cls <= DFD_CLS_NOP;
      end
    end
  end

  assign issue = iss_r;

  // Issue count and last opcode for software visibility
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt_r <= 16'h0000;
      last_r <= 8'h00;
    end else if (iss_r.valid && !iss_r.bubble) begin
      icnt_r <= icnt_r + 16'h0001;
      last_r <= iss_r.opcode;
    end
  end

  // APB: answers in the access cycle; data latched during setup
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign flags_wr = apb_wr && paddr == `DFD_OFS_FLAGS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= 1'b0;
      unique case (paddr)
        `DFD_OFS_CTRL: prdata <= ctrl_r;
        `DFD_OFS_FLAGS: prdata <= {23'h000000, dsp_r, mcu_r};
        `DFD_OFS_ICNT: prdata <= {16'h0000, icnt_r};
        `DFD_OFS_LAST: prdata <= {24'h000000, last_r};
        default: begin
          // Unmapped offsets read zero and report an error
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Control register; only the enable bit is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `DFD_CTRL_RST;
    end else if (apb_wr && paddr == `DFD_OFS_CTRL) begin
      ctrl_r <= {31'h00000000, pwdata[`DFD_CTRL_EN]};
    end
  end

  // Core flags {c, nibble_carry, n, range_err, z}; datapath beats software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_r <= 5'(`DFD_FLAGS_RST);
    end else if (ex_upd.mcu_we) begin
      mcu_r[4] <= ex_upd.carry;
      mcu_r[3] <= ex_upd.nibble_carry;
      mcu_r[2] <= ex_upd.negative;
      mcu_r[1] <= ex_upd.two_comp_range_err;
      // Chained results may only clear zero, so multiword tests work
      mcu_r[0] <= ex_upd.zero_sticky ? (mcu_r[0] && ex_upd.result_zero)
                                     : ex_upd.result_zero;
    end else if (flags_wr) begin
      mcu_r <= pwdata[4:0];
    end
  end

  // DSP flags {clip_b, clip_a, ovf_b, ovf_a}; clip bits hold until cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsp_r <= 4'h0;
    end else begin
      if (ex_upd.dsp_we) begin
        dsp_r[0] <= ex_upd.acc_a_overflow;
        dsp_r[1] <= ex_upd.acc_b_overflow;
      end else if (flags_wr) begin
        dsp_r[1:0] <= pwdata[`DFD_FLG_DSP +: 2];
      end
      // A set in the clearing cycle wins over the clear
      if (ex_upd.dsp_we && ex_upd.acc_a_clip_set) begin
        dsp_r[2] <= 1'b1;
      end else if (flags_wr) begin
        dsp_r[2] <= pwdata[`DFD_FLG_DSP + 2];
      end
      if (ex_upd.dsp_we && ex_upd.acc_b_clip_set) begin
        dsp_r[3] <= 1'b1;
      end else if (flags_wr) begin
        dsp_r[3] <= pwdata[`DFD_FLG_DSP + 3];
      end
    end
  end

  assign mcu_flags = mcu_r;
  assign dsp_flags = dsp_r;

  sequence s_two_first;
    accept && !kill && state_r == ST_RUN && live_cls == DFD_CLS_TWO;
  endsequence

  sequence s_two_done;
    !iss_r.valid ##0 (state_r == ST_SECOND);
  endsequence

  a_two_word_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_two_first |=> s_two_done)
    else $error("two-word first half issued early");

  a_two_word_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && state_r == ST_SECOND) |=> (iss_r.valid && iss_r.cycles == 2'd2
      && !iss_r.bubble && iss_r.program_address_constant[0] == 1'b0))
    else $error("two-word issue wrong");

  a_hold_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && !kill && state_r == ST_RUN && live_cls == DFD_CLS_TBL)
      |=> !fetch_ready ##1 fetch_ready == ctrl_r[`DFD_CTRL_EN])
    else $error("table op stall length wrong");

  a_squash_bubble: assert property (@(posedge pclk) disable iff (!presetn)
    kill |=> (iss_r.valid && iss_r.bubble))
    else $error("squashed word not replaced by bubble");

  a_redirect_one: assert property (@(posedge pclk) disable iff (!presetn)
    (ex_redirect && !ex_skip) |=> squash_cnt_r == 2'd1 && !skip_r)
    else $error("redirect did not arm one bubble");

  a_skip_two_word: assert property (@(posedge pclk) disable iff (!presetn)
    (kill && skip_r && live_cls == DFD_CLS_TWO && !ex_redirect && !ex_skip)
      |=> squash_cnt_r == 2'd1)
    else $error("skip over two-word lost its second bubble");

  a_sticky_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ex_upd.mcu_we && ex_upd.zero_sticky && !ex_upd.result_zero)
      |=> !mcu_r[0])
    else $error("sticky zero not cleared");

  a_clip_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (dsp_r[2] && !flags_wr) |=> dsp_r[2])
    else $error("clip flag dropped without a clear");

  a_byte_literal: assert property (@(posedge pclk) disable iff (!presetn)
    (iss_r.valid && iss_r.cls == DFD_CLS_LIT
      && iss_r.fields.size == DFD_SZ_BYTE)
      |-> iss_r.fields.ten_bit_constant <= `DFD_BYTE_LIT_MAX)
    else $error("byte literal above 255");

  // Fixed stalls issue bubbles, never stale work
  a_hold_bubble: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_HOLD |=> iss_r.valid && iss_r.bubble)
    else $error("stall cycle without a bubble");

  // A lone zero-opcode word costs one cycle and does nothing
  a_lone_second: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && !kill && state_r == ST_RUN && fetch_word[23:16] == 8'h00)
      |=> iss_r.cls == DFD_CLS_NOP && iss_r.cycles == 2'd1)
    else $error("lone second word not a no-operation");

  // A bad top byte in a second word is reported, not hidden
  a_second_err: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && state_r == ST_SECOND && fetch_word[23:16] != 8'h00)
      |=> iss_r.second_word_err)
    else $error("second word top byte error missed");

  // Register operations never stall
  a_plain_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && !kill && state_r == ST_RUN && live_cls == DFD_CLS_WB3)
      |=> iss_r.valid && iss_r.cycles == 2'd1)
    else $error("register operation not one cycle");

  // A bubble must not carry a live class into the datapath
  a_bubble_nop: assert property (@(posedge pclk) disable iff (!presetn)
    (iss_r.valid && iss_r.bubble) |-> iss_r.cls == DFD_CLS_NOP)
    else $error("bubble with a live class");

  // Offsets above the map answer with an error
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && paddr[7:4] != 4'h0) |=> pslverr)
    else $error("unmapped offset without error");
endmodule // dfd_decoder

// ### verilog/dfd_consts.svh
// Constants of the instruction format decoder: offsets, fields, opcodes
// Function
// - A single word is 24 bits; top 8 bits are opcode, rest operands.
// - Exactly three instruction types use two program words.
// - Two-word instructions span 48 bits; second word top byte is zero.
// - A second word executed alone behaves as a no-operation.
// - Single word takes one cycle, two when condition true or PC altered.
// - Jumps, indirect calls, table ops and returns take two or three cycles.
// - Taken skip costs two cycles, three when skipping a two-word one.
// - Double-word moves and all two-word instructions take two cycles.
// - Register ops decode base, source with mode, destination with mode.
// - File ops decode a memory address and destination file or W0.
// - Bit ops pick register or location; bit from literal or base reg.
// - Literal ops use base and literal; separate destination only if differs.
// - MAC ops select accumulator, multiplicands, prefetches and write-back.
// - Other DSP ops name accumulator, operand with mode, optional shift.
// - Write-back selects W13 directly or its location, post-increment 2.
// - Bit index field is 4 bits selecting positions 0 to 15.
// - Ten-bit literal is 0 to 255 in byte mode, up to 1023 in word.
// - Five status flags; the zero flag is sticky on chained results.
// - Four DSP flags: overflow and saturation for accumulators A and B.
// - Operand size is byte, word or double word; word by default.
`ifndef DFD_CONSTS_SVH
`define DFD_CONSTS_SVH
// Register byte offsets
`define DFD_OFS_CTRL 8'h00
`define DFD_OFS_FLAGS 8'h04
`define DFD_OFS_ICNT 8'h08
`define DFD_OFS_LAST 8'h0c
`define DFD_CTRL_RST 32'h0000_0001
`define DFD_FLAGS_RST 9'h000
// Control and flag register bit positions
`define DFD_CTRL_EN 0
`define DFD_FLG_DSP 5
// Opcodes of the control group
`define DFD_OP_NOP 8'h00
`define DFD_OP_JMP 8'h01
`define DFD_OP_CALL2 8'h02
`define DFD_OP_GOTO2 8'h04
`define DFD_OP_IND 8'h05
`define DFD_OP_RET 8'h06
`define DFD_OP_RETI 8'h07
`define DFD_OP_LOOP2 8'h08
`define DFD_OP_TBLR 8'h0a
`define DFD_OP_TBLW 8'h0b
// Operand field positions inside the low 16 bits
`define DFD_F_SRC 0
`define DFD_F_SMODE 4
`define DFD_F_DST 6
`define DFD_F_DMODE 10
`define DFD_F_BASE 12
`define DFD_F_BITIDX 8
`define DFD_F_BITIND 13
`define DFD_F_TOWREG 13
`define DFD_F_LITBASE 10
`define DFD_F_FORM 14
`define DFD_F_ACC 15
`define DFD_F_MULT 12
`define DFD_F_XPF 8
`define DFD_F_XPD 6
`define DFD_F_YPF 2
`define DFD_F_YPD 0
`define DFD_F_SHIFT 6
`define DFD_F_SHREG 14
// Write-back register number and its post-increment
`define DFD_AWB_REG 4'hd
`define DFD_AWB_INC 2'h2
`define DFD_BYTE_LIT_MAX 10'h0ff
`endif

// ### verilog/dfd_pkg.sv
// Types and opcode classing shared by the decoder files
package dfd_pkg;
  `include "dfd_consts.svh"

  typedef enum logic [3:0] {
    DFD_CLS_NOP = 4'h0, DFD_CLS_CTRL = 4'h1, DFD_CLS_JMP = 4'h2,
    DFD_CLS_RET = 4'h3, DFD_CLS_TBL = 4'h4, DFD_CLS_TWO = 4'h5,
    DFD_CLS_BRC = 4'h6, DFD_CLS_SKIP = 4'h7, DFD_CLS_WB3 = 4'h8,
    DFD_CLS_FILE = 4'h9, DFD_CLS_LIT = 4'ha, DFD_CLS_BIT = 4'hb,
    DFD_CLS_MOVD = 4'hc, DFD_CLS_MAC = 4'hd, DFD_CLS_DSP = 4'he
  } dfd_cls_t;

  typedef enum logic [1:0] {
    DFD_SZ_WORD = 2'b00, DFD_SZ_BYTE = 2'b01, DFD_SZ_DWORD = 2'b10
  } dfd_size_t;

  typedef enum logic [1:0] {
    DFD_AWB_NONE = 2'b00, DFD_AWB_DIRECT = 2'b01, DFD_AWB_POSTINC = 2'b10
  } dfd_awb_t;

  typedef struct packed {
    logic [3:0] base_operand_reg;
    logic [3:0] source_operand_reg;
    logic [1:0] src_mode;
    logic [3:0] dest_operand_reg;
    logic [1:0] dst_mode;
    dfd_size_t size;
    logic [3:0] bit_index_field;
    logic bit_from_base;
    logic [9:0] ten_bit_constant;
    logic lit_range_err;
    logic [12:0] file_addr;
    logic to_default_work_reg_zero;
    logic acc_b;
    logic [2:0] mult_pair;
    logic [3:0] x_prefetch;
    logic [1:0] x_dest;
    logic [3:0] y_prefetch;
    logic [1:0] y_dest;
    dfd_awb_t acc_writeback_reg;
    logic [3:0] awb_reg_num;
    logic [1:0] awb_post_inc;
    logic shift_from_reg;
    logic [5:0] shift_amount;
  } dfd_fields_t;

  typedef struct packed {
    logic valid;
    logic bubble;
    dfd_cls_t cls;
    logic [7:0] opcode;
    logic [1:0] cycles;
    logic [22:0] program_address_constant;
    logic second_word_err;
    dfd_fields_t fields;
  } dfd_issue_t;

  typedef struct packed {
    logic mcu_we;
    logic zero_sticky;
    logic carry;
    logic nibble_carry;
    logic negative;
    logic two_comp_range_err;
    logic result_zero;
    logic dsp_we;
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_clip_set;
    logic acc_b_clip_set;
  } dfd_alu_upd_t;

  // Class of an opcode; used for the live word, the held first word and skips
  function automatic dfd_cls_t dfd_op_class(input logic [7:0] op);
    dfd_cls_t c;
    c = DFD_CLS_WB3;
    if (op[7:4] == 4'h0) begin
      unique case (op)
        `DFD_OP_NOP: c = DFD_CLS_NOP;
        `DFD_OP_JMP, `DFD_OP_IND: c = DFD_CLS_JMP;
        `DFD_OP_CALL2, `DFD_OP_GOTO2, `DFD_OP_LOOP2: c = DFD_CLS_TWO;
        `DFD_OP_RET, `DFD_OP_RETI: c = DFD_CLS_RET;
        `DFD_OP_TBLR, `DFD_OP_TBLW: c = DFD_CLS_TBL;
        default: c = DFD_CLS_CTRL;
      endcase
    end else begin
      unique case (op[7:4])
        4'h3: c = DFD_CLS_BRC;
        4'h6: c = DFD_CLS_FILE;
        4'h7: c = DFD_CLS_LIT;
        4'h8, 4'h9: c = DFD_CLS_BIT;
        4'ha: c = DFD_CLS_SKIP;
        4'hb: c = DFD_CLS_MOVD;
        4'hc: c = DFD_CLS_MAC;
        4'hd: c = DFD_CLS_DSP;
        default: c = DFD_CLS_WB3;
      endcase
    end
    return c;
  endfunction

  // Fixed bubbles that follow an issue, apart from redirects and skips
  function automatic logic [1:0] dfd_fixed_extra(input dfd_cls_t c);
    logic [1:0] n;
    n = 2'd0;
    if (c == DFD_CLS_TBL || c == DFD_CLS_MOVD || c == DFD_CLS_RET) begin
      n = 2'd1;
    end
    return n;
  endfunction
endpackage

// ### verilog/dfd_opfields.sv
// Operand field extraction per instruction class
module dfd_opfields import dfd_pkg::*; (
  input wire logic [23:0] word,
  input wire dfd_cls_t cls,
  output dfd_fields_t fields
);
  logic [15:0] w;
  logic [7:0] op;
  dfd_size_t sz;

  assign w = word[15:0];
  assign op = word[23:16];

  // Size comes from the low opcode bits; the unused code falls back to word
  always_comb begin
    unique case (op[1:0])
      2'b01: sz = DFD_SZ_BYTE;
      2'b10: sz = DFD_SZ_DWORD;
      default: sz = DFD_SZ_WORD;
    endcase
  end

  // One case per class; fields a class does not use stay at zero, apart from awb_reg_num at 13
  always_comb begin
    fields = '0;
    fields.size = DFD_SZ_WORD;
    fields.awb_reg_num = `DFD_AWB_REG;
    unique case (cls)
      DFD_CLS_WB3, DFD_CLS_MOVD: begin
        fields.base_operand_reg = w[`DFD_F_BASE +: 4];
        fields.source_operand_reg = w[`DFD_F_SRC +: 4];
        fields.src_mode = w[`DFD_F_SMODE +: 2];
        fields.dest_operand_reg = w[`DFD_F_DST +: 4];
        fields.dst_mode = w[`DFD_F_DMODE +: 2];
        fields.size = (cls == DFD_CLS_MOVD) ? DFD_SZ_DWORD : sz;
      end
      DFD_CLS_FILE: begin
        fields.file_addr = w[12:0];
        fields.to_default_work_reg_zero = w[`DFD_F_TOWREG];
        fields.size = (sz == DFD_SZ_BYTE) ? DFD_SZ_BYTE : DFD_SZ_WORD;
      end
      DFD_CLS_BIT, DFD_CLS_SKIP: begin
        fields.source_operand_reg = w[`DFD_F_SRC +: 4];
        fields.src_mode = w[`DFD_F_SMODE +: 2];
        fields.bit_index_field = w[`DFD_F_BITIDX +: 4];
        fields.bit_from_base = w[`DFD_F_BITIND];
        fields.base_operand_reg = w[`DFD_F_BASE +: 4];
      end
      DFD_CLS_LIT: begin
        fields.size = (sz == DFD_SZ_BYTE) ? DFD_SZ_BYTE : DFD_SZ_WORD;
        if (!w[`DFD_F_FORM]) begin
          // Short form: destination is the base register itself
          fields.base_operand_reg = {2'b00, w[`DFD_F_LITBASE +: 2]} |
                                    {op[3:2], 2'b00};
          fields.dest_operand_reg = fields.base_operand_reg;
          if (sz == DFD_SZ_BYTE) begin
            // Byte mode keeps the literal in 0..255 and flags overrange
            fields.ten_bit_constant = {2'b00, w[7:0]};
            fields.lit_range_err = w[9:0] > `DFD_BYTE_LIT_MAX;
          end else begin
            fields.ten_bit_constant = w[9:0];
          end
        end else begin
          fields.base_operand_reg = w[`DFD_F_BASE +: 4];
          fields.dest_operand_reg = {2'b00, w[`DFD_F_LITBASE +: 2]} |
                                    {w[9:8], 2'b00};
          fields.dst_mode = w[`DFD_F_DST +: 2];
          fields.ten_bit_constant = {4'h0, w[5:0]};
        end
      end
      DFD_CLS_MAC: begin
        fields.acc_b = w[`DFD_F_ACC];
        fields.mult_pair = w[`DFD_F_MULT +: 3];
        fields.x_prefetch = w[`DFD_F_XPF +: 4];
        fields.x_dest = w[`DFD_F_XPD +: 2];
        fields.y_prefetch = w[`DFD_F_YPF +: 4];
        fields.y_dest = w[`DFD_F_YPD +: 2];
        unique case (op[1:0])
          2'b01: fields.acc_writeback_reg = DFD_AWB_DIRECT;
          2'b10: begin
            fields.acc_writeback_reg = DFD_AWB_POSTINC;
            fields.awb_post_inc = `DFD_AWB_INC;
          end
          default: fields.acc_writeback_reg = DFD_AWB_NONE;
        endcase
      end
      DFD_CLS_DSP: begin
        fields.acc_b = w[`DFD_F_ACC];
        fields.source_operand_reg = w[`DFD_F_SRC +: 4];
        fields.src_mode = w[`DFD_F_SMODE +: 2];
        fields.shift_from_reg = w[`DFD_F_SHREG];
        fields.shift_amount = w[`DFD_F_SHIFT +: 6];
      end
      default: begin
        fields.size = DFD_SZ_WORD;
      end
    endcase
  end
endmodule // dfd_opfields

// ### tb/dfd_fetch_model.sv
// Program memory model: offers queued words, each held until taken
module dfd_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [23:0] fetch_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] words[$];
  bit slow = 0;
  // Idle data toggles so a stale word never looks like a fresh one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_valid <= 1'b0;
      fetch_word <= 24'h000000;
    end else if (!fetch_valid || fetch_ready) begin
      if (fetch_valid) begin
        void'(words.pop_front());
      end
      if (words.size() != 0 && !(slow && $urandom_range(1) == 0)) begin
        fetch_valid <= 1'b1;
        fetch_word <= words[0];
      end else begin
        fetch_valid <= 1'b0;
        fetch_word <= ~fetch_word;
      end
    end
  end
endmodule // dfd_fetch_model

// ### tb/dfd_decoder_tb_top.sv
// Self-checking bench of the instruction format decoder
module dfd_decoder_tb_top import dfd_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic fetch_valid, fetch_ready, ex_redirect, ex_skip;
  logic [23:0] fetch_word;
  dfd_alu_upd_t ex_upd;
  dfd_issue_t issue;
  logic [4:0] mcu_flags;
  logic [3:0] dsp_flags;
  logic [34:0] exp_q[$];
  logic [34:0] got;
  dfd_fields_t fq[$];
  int miscompares = 0;
  int samples_checked = 0;
  int issued = 0;
  dfd_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_ready(fetch_ready), .ex_redirect(ex_redirect),
    .ex_skip(ex_skip), .ex_upd(ex_upd), .issue(issue),
    .mcu_flags(mcu_flags), .dsp_flags(dsp_flags));
  dfd_fetch_model mem (.pclk(pclk), .presetn(presetn),
    .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word));
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic check(input logic [34:0] g, input logic [34:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [34:0] ex(input logic b, input logic [7:0] op,
                                     input logic [1:0] c);
    return {b, op, c, 24'h0};
  endfunction
  // One APB transfer; starting on a fresh edge keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Queue a word and, unless zero, the issue it must produce
  task automatic feed(input logic [23:0] w, input logic [34:0] e);
    mem.words.push_back(w);
    if (e != 0) begin
      exp_q.push_back(e);
    end
  endtask
  task automatic upd(input logic [11:0] u, input logic [8:0] f);
    @(posedge pclk);
    ex_upd <= u;
    @(posedge pclk);
    ex_upd <= '0;
    @(negedge pclk);
    check({dsp_flags, mcu_flags}, f);
  endtask
  task automatic drain(input string name);
    int n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    check(exp_q.size(), 0);
    $display("test %s done", name);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Issues compared in order; address only matters for two-word opcodes
  always @(negedge pclk) begin
    if (issue.valid === 1'b1) begin
      got = {issue.bubble, issue.opcode, issue.cycles,
        issue.second_word_err, issue.program_address_constant};
      if (issue.bubble) begin
        got[33:0] = '0;
      end else if (!(issue.opcode inside {8'h02, 8'h04, 8'h08})) begin
        got[23:0] = '0;
      end
      issued += !issue.bubble;
      check(got, exp_q.size() ? exp_q.pop_front() : '1);
      if (!issue.bubble && fq.size() != 0) begin
        samples_checked++;
        if (issue.fields !== fq.pop_front()) begin
          miscompares++;
          $display("[ERR] %0t operand fields %h", $time, issue.fields);
        end
      end
    end
  end
  // Watchdog sized well above the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [7:0] op;
    logic [15:0] lo;
    logic [23:0] w2;
    dfd_fields_t f, g;
    logic [7:0] xop[5] = '{8'h0a, 8'h0b, 8'h06, 8'h07, 8'hb4};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ex_redirect, ex_skip, ex_upd, presetn} = '0;
    void'($urandom(32'h2bad0675));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    check(rd, 32'h1);
    apb(0, 8'h10, 32'h5);
    check({err, rd}, {1'b1, 32'h0});
    apb(1, 8'h00, 0);
    @(negedge pclk);
    check(fetch_ready, 0);
    apb(1, 8'h00, 1);
    $display("test registers done");
    // Random single-word traffic with a stalling memory
    mem.slow = 1;
    repeat (24) begin
      op = {4'(48'h1245_6789_cdef >> (4 * $urandom_range(11))), 4'($urandom)};
      feed({op, 16'($urandom)}, ex(0, op, 1));
    end
    drain("single");
    mem.slow = 0;
    foreach (xop[i]) begin
      feed({xop[i], 16'h0}, ex(0, xop[i], 2));
      exp_q.push_back(ex(1, 0, 0));
    end
    drain("fixed extra");
    lo = 16'($urandom) & 16'hfffe;
    w2 = 24'($urandom);
    feed({8'h02, lo}, 0);
    feed({8'h00, w2[15:0]},
         {1'b0, 8'h02, 2'd2, 1'b0, w2[6:0], lo[15:1], 1'b0});
    feed({8'h08, lo}, 0);
    feed({8'h5a, w2[15:0]},
         {1'b0, 8'h08, 2'd2, 1'b1, w2[6:0], lo[15:1], 1'b0});
    feed({8'h00, w2[15:0]}, ex(0, 8'h00, 1));
    drain("two word");
    @(posedge pclk);
    ex_redirect <= 1'b1;
    @(posedge pclk);
    ex_redirect <= 1'b0;
    feed(24'h401234, ex(1, 0, 0));
    feed(24'h410000, ex(0, 8'h41, 1));
    drain("redirect");
    @(posedge pclk);
    ex_skip <= 1'b1;
    @(posedge pclk);
    ex_skip <= 1'b0;
    feed(24'h040000, ex(1, 0, 0));
    feed(24'h000000, ex(1, 0, 0));
    feed(24'h420000, ex(0, 8'h42, 1));
    drain("skip");
    // Operand fields of a byte register word and a multiply word
    f = '0;
    f.awb_reg_num = 4'hd;
    f.size = DFD_SZ_BYTE;
    {f.base_operand_reg, f.source_operand_reg} = 8'h5c;
    {f.src_mode, f.dest_operand_reg, f.dst_mode} = 8'he2;
    feed(24'h415a3c, ex(0, 8'h41, 1));
    fq.push_back(f);
    g = '0;
    g.awb_reg_num = 4'hd;
    {g.acc_b, g.mult_pair, g.x_prefetch} = 8'h98;
    {g.x_dest, g.y_prefetch, g.y_dest} = 8'h76;
    g.acc_writeback_reg = DFD_AWB_POSTINC;
    g.awb_post_inc = 2'h2;
    feed(24'hc29876, ex(0, 8'hc2, 1));
    fq.push_back(g);
    drain("fields");
    upd(12'hab9, 9'b1001_10101);
    upd(12'hc10, 9'b1000_00000);
    upd(12'hc20, 9'b1000_00000);
    apb(0, 8'h04, 0);
    check(rd, 32'h100);
    apb(1, 8'h04, 0);
    apb(0, 8'h04, 0);
    check(rd, 0);
    apb(0, 8'h08, 0);
    check(rd[15:0], issued[15:0]);
    $display("test flags done");
    end_of_test();
  end
endmodule // dfd_decoder_tb_top
